/* tssp_pkg.sv */
package tssp_pkg;
  // Device register indices on the configuration link
  localparam logic [6:0] DEV_MAIN      = 7'h00;   // Main control
  localparam logic [6:0] DEV_INTERFACE = 7'h01;   // Pin and clock options
  localparam logic [6:0] DEV_MODEM     = 7'h0B;   // Test sequence control
  localparam logic [6:0] DEV_LOCK      = 7'h0C;   // Lock pin select
  localparam logic [6:0] DEV_STATUS    = 7'h0D;   // Read-only lock status
  // Device field positions
  localparam int MAIN_PA_ON_BIT  = 0;             // Internal amplifier on
  localparam int MAIN_PDS_LSB    = 4;             // power_down_select[1:0]
  localparam int INTF_BYPASS_BIT = 0;             // oscillator_bypass
  localparam int INTF_WAIT_BIT   = 1;             // clock_pin_wait_option
  localparam int INTF_FOLLOW_BIT = 2;             // external_amp_follow
  localparam int INTF_LEVEL_BIT  = 3;             // external_amp_level
  localparam int MODEM_TSE_BIT   = 0;             // test_sequence_enable
  localparam int LOCK_SEL_LSB    = 4;             // lock select[3:0]
  // Device reset values
  localparam logic [7:0] MAIN_RST  = 8'h00;
  localparam logic [7:0] INTF_RST  = 8'h00;
  localparam logic [7:0] MODEM_RST = 8'h00;
  localparam logic [7:0] LOCK_RST  = 8'h00;
  // Power-down select and lock select codes
  localparam logic [1:0] PDS_NORMAL = 2'h0;
  localparam logic [1:0] PDS_WAIT   = 2'h1;
  localparam logic [3:0] LSEL_LOW   = 4'h0;
  localparam logic [3:0] LSEL_HIGH  = 4'h1;
  localparam logic [3:0] LSEL_LOCK  = 4'h2;
  // Test sequence generator
  localparam logic [8:0] PN_SEED = 9'h1FF;
  localparam int         PN_TAP  = 4;             // x^5 term, x^9 is bit 8
  // Bit clock half period in pclk cycles
  localparam logic [3:0] BIT_HALF = 4'h8;
  // Host APB register byte offsets
  localparam logic [11:0] H_CMD    = 12'h000;
  localparam logic [11:0] H_STATUS = 12'h004;
  localparam logic [11:0] H_TXDATA = 12'h008;
  localparam logic [11:0] H_CTRL   = 12'h00C;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_WE_BIT   = 16;
  localparam int CTRL_ARM     = 0;
  localparam int CTRL_AUTO    = 1;
  localparam int CTRL_IDLE    = 2;
  localparam int CTRL_TXEN    = 3;
  localparam int FIFO_DEPTH   = 8;
  localparam int FIFO_WIDTH   = 8;
endpackage

/* tssp_if.sv */
interface tssp_if;
  logic       cfg_req;          // Host: one-cycle access request
  logic       cfg_we;           // Host: write when high
  logic [6:0] cfg_addr;         // Host: device register index
  logic [7:0] cfg_wdata;        // Host: write data
  logic       cfg_ack;          // Device: one-cycle answer
  logic [7:0] cfg_rdata;        // Device: read data with ack
  logic       tx_serial_input;  // Host: transmit data line
  logic       bit_clock_pin;    // Device: bit clock or lock signal
  modport dev  (input cfg_req, cfg_we, cfg_addr, cfg_wdata, tx_serial_input,
                output cfg_ack, cfg_rdata, bit_clock_pin);
  modport host (output cfg_req, cfg_we, cfg_addr, cfg_wdata, tx_serial_input,
                input cfg_ack, cfg_rdata, bit_clock_pin);
endinterface

/* tssp_fifo.sv */
module tssp_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         pclk,       // Clock
  input  wire logic         presetn,    // Async reset, active low
  input  wire logic         in_valid,   // Write request
  output logic              in_ready,   // Not full
  input  wire logic [W-1:0] in_data,    // Write data
  output logic              out_valid,  // Not empty
  input  wire logic         out_ready,  // Pop request
  output logic [W-1:0]      out_data    // Head word
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];               // Storage
  logic [AW-1:0] wr_reg;                // Write pointer
  logic [AW-1:0] rd_reg;                // Read pointer
  logic [AW:0]   cnt_reg;               // Fill level
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_reg != (AW+1)'(D));
  assign out_valid = (cnt_reg != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_ready & out_valid;
  assign out_data  = mem[rd_reg];

  // Storage has no reset; only written words are ever read
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end

  // Pointers and level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(D-1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(D-1)) ? '0 : rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // tssp_fifo

/* tssp_device.sv */
// How it works
// - Enabled test sequence uses x^9+x^5+1 polynomial
// - Host toggles data line before sequence starts
// - Host selects power-down code 01 for lock wait
// - Wait option holds bit clock high while unlocked
// - Bit clock drops low once synthesizer locks
// - Host writes 00; normal bit clock resumes
// - Host waits for lock before amplifier ramp
// - Follow mode: enable pin tracks internal amplifier
// - Level bit sets enable pin active polarity
// - No follow: enable pin copies level bit
// - Lock select 0000 low, 0001 high
// - Lock select 0010 shows synthesizer lock
// - Host sets bypass for rail-to-rail clock
// - Host clears bypass for sine or crystal
module tssp_device (
  tssp_if.dev       link,               // Configuration and data link
  input  wire logic pclk,               // Reference-derived clock
  input  wire logic presetn,            // Async reset, active low
  input  wire logic synth_locked_async, // Synthesizer lock, analog domain
  output logic      modulator_data,     // Bit to the modulator
  output logic      pa_on,              // Internal amplifier on
  output logic      external_amp_enable_pin, // External amplifier enable
  output logic      lock_pin,           // Lock status pin
  output logic      oscillator_bypass   // Reference input type select
);
  logic [7:0] main_reg;                 // Main control
  logic [7:0] intf_reg;                 // Pin options
  logic [7:0] modem_reg;                // Test sequence control
  logic [7:0] lock_reg;                 // Lock pin select
  logic       ack_reg;                  // Link answer
  logic [7:0] rdata_reg;                // Link read data
  logic       sync1_reg;                // Lock synchroniser stage 1
  logic       sync2_reg;                // Stage 2
  logic       sync3_reg;                // Stage 3
  logic       locked_reg;               // Filtered lock status
  logic [3:0] div_reg;                  // Bit clock divider
  logic       bitclk_reg;               // Free-running bit clock
  logic       pin_reg;                  // Bit clock pin level
  logic       line_prev_reg;            // Previous data line level
  logic       pn_run_reg;               // Sequence started
  logic [8:0] pn_reg;                   // Sequence generator state
  logic       mod_reg;                  // Modulator bit
  logic       pa_pin_reg;               // Amplifier enable pin
  logic       lock_pin_reg;             // Lock pin
  logic       tick;                     // Divider wrap
  logic       rise;                     // Bit clock about to rise
  logic [1:0] pds;                      // Power-down select
  logic       pin_next;                 // Next bit clock pin level
  logic       pa_next;                  // Next amplifier enable
  logic       lock_next;                // Next lock pin
  logic [7:0] rd_next;                  // Read mux

  // Field views
  assign pds   = main_reg[tssp_pkg::MAIN_PDS_LSB +: 2];
  assign pa_on = main_reg[tssp_pkg::MAIN_PA_ON_BIT];
  assign oscillator_bypass = intf_reg[tssp_pkg::INTF_BYPASS_BIT];

  // Read decode, shared by the read mux only but kept tidy as a function
  function automatic logic [7:0] dev_read(input logic [6:0] a);
    case (a)
      tssp_pkg::DEV_MAIN:      dev_read = main_reg;
      tssp_pkg::DEV_INTERFACE: dev_read = intf_reg;
      tssp_pkg::DEV_MODEM:     dev_read = modem_reg;
      tssp_pkg::DEV_LOCK:      dev_read = lock_reg;
      tssp_pkg::DEV_STATUS:    dev_read = {7'h00, locked_reg};
      default:                 dev_read = 8'h00;
    endcase
  endfunction

  assign rd_next = dev_read(link.cfg_addr);

  // Register writes from the link; unmapped writes are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_reg  <= tssp_pkg::MAIN_RST;
      intf_reg  <= tssp_pkg::INTF_RST;
      modem_reg <= tssp_pkg::MODEM_RST;
      lock_reg  <= tssp_pkg::LOCK_RST;
    end else if (link.cfg_req && link.cfg_we) begin
      case (link.cfg_addr)
        tssp_pkg::DEV_MAIN:      main_reg  <= link.cfg_wdata;
        tssp_pkg::DEV_INTERFACE: intf_reg  <= link.cfg_wdata;
        tssp_pkg::DEV_MODEM:     modem_reg <= link.cfg_wdata;
        tssp_pkg::DEV_LOCK:      lock_reg  <= link.cfg_wdata;
        default: ;
      endcase
    end
  end

  // Link answer: one cycle after every request, reads or writes alike
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      ack_reg <= link.cfg_req;
      if (link.cfg_req && !link.cfg_we) begin
        rdata_reg <= rd_next;
      end
    end
  end

  assign link.cfg_ack   = ack_reg;
  assign link.cfg_rdata = rdata_reg;

  // Lock input crosses from the analog side through three stages;
  // a change is accepted only when stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg  <= 1'b0;
      sync2_reg  <= 1'b0;
      sync3_reg  <= 1'b0;
      locked_reg <= 1'b0;
    end else begin
      sync1_reg <= synth_locked_async;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      if (sync2_reg == sync3_reg) begin
        locked_reg <= sync3_reg;
      end
    end
  end

  // Bit clock divider runs always, so the phase is stable across modes
  assign tick = (div_reg == tssp_pkg::BIT_HALF - 4'h1);
  assign rise = tick & ~bitclk_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg  <= 4'h0;
      bitclk_reg <= 1'b0;
    end else begin
      div_reg <= tick ? 4'h0 : div_reg + 4'h1;
      if (tick) begin
        bitclk_reg <= ~bitclk_reg;
      end
    end
  end

  // Bit clock pin: normal clock, lock wait signal, or held low
  always_comb begin
    case (pds)
      tssp_pkg::PDS_NORMAL: pin_next = bitclk_reg;
      tssp_pkg::PDS_WAIT: begin
        // High while unlocked, low after lock: the host sees a falling edge
        if (intf_reg[tssp_pkg::INTF_WAIT_BIT]) begin
          pin_next = ~locked_reg;
        end else begin
          pin_next = 1'b0;
        end
      end
      default: pin_next = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_reg <= 1'b0;
    end else begin
      pin_reg <= pin_next;
    end
  end

  assign link.bit_clock_pin = pin_reg;

  // Sequence arming: it runs only after the data line has moved while
  // enabled; disabling rearms so each enable needs a fresh transition
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_prev_reg <= 1'b0;
      pn_run_reg    <= 1'b0;
    end else begin
      line_prev_reg <= link.tx_serial_input;
      if (!modem_reg[tssp_pkg::MODEM_TSE_BIT]) begin
        pn_run_reg <= 1'b0;
      end else if (link.tx_serial_input != line_prev_reg) begin
        pn_run_reg <= 1'b1;
      end
    end
  end

  // Generator and data capture advance once per bit period at the rising
  // edge while power-down select is 00; the seed is nonzero and the all-zero state is unreachable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pn_reg  <= tssp_pkg::PN_SEED;
      mod_reg <= 1'b0;
    end else if (rise && pds == tssp_pkg::PDS_NORMAL) begin
      if (pn_run_reg) begin
        mod_reg <= pn_reg[8];
        pn_reg  <= {pn_reg[7:0], pn_reg[8] ^ pn_reg[tssp_pkg::PN_TAP]};
      end else begin
        mod_reg <= link.tx_serial_input;
        if (!modem_reg[tssp_pkg::MODEM_TSE_BIT]) begin
          pn_reg <= tssp_pkg::PN_SEED;
        end
      end
    end
  end

  assign modulator_data = mod_reg;

  // External amplifier enable: follow the internal amplifier with the
  // chosen polarity, or act as a plain output copying the level bit
  always_comb begin
    if (intf_reg[tssp_pkg::INTF_FOLLOW_BIT]) begin
      pa_next = pa_on ? intf_reg[tssp_pkg::INTF_LEVEL_BIT]
                      : ~intf_reg[tssp_pkg::INTF_LEVEL_BIT];
    end else begin
      pa_next = intf_reg[tssp_pkg::INTF_LEVEL_BIT];
    end
  end

  // Lock pin select; unused codes park the pin low
  always_comb begin
    case (lock_reg[tssp_pkg::LOCK_SEL_LSB +: 4])
      tssp_pkg::LSEL_LOW:  lock_next = 1'b0;
      tssp_pkg::LSEL_HIGH: lock_next = 1'b1;
      tssp_pkg::LSEL_LOCK: lock_next = locked_reg;
      default:             lock_next = 1'b0;
    endcase
  end

  // Pin outputs come from flip-flops to avoid glitches on the board
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pa_pin_reg   <= 1'b0;
      lock_pin_reg <= 1'b0;
    end else begin
      pa_pin_reg   <= pa_next;
      lock_pin_reg <= lock_next;
    end
  end

  assign external_amp_enable_pin = pa_pin_reg;
  assign lock_pin                = lock_pin_reg;
endmodule // tssp_device

/* tssp_host.sv */
module tssp_host (
  tssp_if.host        link,     // Link to the device
  input  wire logic        pclk,     // Clock
  input  wire logic        presetn,  // Async reset, active low
  input  wire logic        psel,     // APB select
  input  wire logic        penable,  // APB access phase
  input  wire logic        pwrite,   // APB direction
  input  wire logic [11:0] paddr,    // APB byte address
  input  wire logic [31:0] pwdata,   // APB write data
  output logic        pready,   // APB ready
  output logic [31:0] prdata,   // APB read data
  output logic        pslverr   // APB error on unmapped address
);
  logic [3:0]  ctrl_reg;        // Arm, auto, idle level, tx enable
  logic        busy_reg;        // Link access outstanding
  logic        lock_seen_reg;   // Sticky lock event
  logic        resume_reg;      // Automatic resume pending
  logic [7:0]  rdata_reg;       // Last device read
  logic [7:0]  shadow_reg;      // Copy of device main control
  logic        req_reg;         // Link request pulse
  logic        we_reg;          // Link direction
  logic [6:0]  addr_reg;        // Link index
  logic [7:0]  wdata_reg;       // Link data
  logic [31:0] prdata_reg;      // Read data captured in setup
  logic        clk_prev_reg;    // Previous bit clock level
  logic        line_reg;        // Data line
  logic [7:0]  sh_reg;          // Serializer shift register
  logic [2:0]  left_reg;        // Bits still to send
  logic        access;
  logic        mapped;
  logic        cmd_fire;
  logic        res_fire;
  logic        fall;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic        fifo_pop;
  logic [7:0]  fifo_data;

  assign access = psel & penable;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr[11:4] == 8'h00);
  // Stall a command while the link is busy and a push while full
  assign pready = access & ~(pwrite && paddr == tssp_pkg::H_CMD && busy_reg)
                         & ~(pwrite && paddr == tssp_pkg::H_TXDATA && !fifo_in_ready);
  assign pslverr  = pready & ~mapped;
  assign prdata   = prdata_reg;
  assign cmd_fire = pready && pwrite && paddr == tssp_pkg::H_CMD;
  assign res_fire = resume_reg && !busy_reg && !cmd_fire;
  assign fall     = clk_prev_reg & ~link.bit_clock_pin;

  // Read data is prepared in the setup phase so it stands in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable) begin
      case (paddr)
        tssp_pkg::H_STATUS: prdata_reg <= {16'h0000, rdata_reg, 3'h0, link.bit_clock_pin,
                                           ~fifo_out_valid, fifo_in_ready, lock_seen_reg,
                                           busy_reg};
        tssp_pkg::H_CTRL:   prdata_reg <= {28'h000_0000, ctrl_reg};
        default:            prdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // Control register and sticky lock flag; a new event beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg      <= 4'h0;
      lock_seen_reg <= 1'b0;
      clk_prev_reg  <= 1'b0;
    end else begin
      clk_prev_reg <= link.bit_clock_pin;
      if (pready && pwrite && paddr == tssp_pkg::H_CTRL) begin
        ctrl_reg <= pwdata[3:0];
      end
      if (fall && ctrl_reg[tssp_pkg::CTRL_ARM]) begin
        lock_seen_reg <= 1'b1;
      end else if (pready && pwrite && paddr == tssp_pkg::H_STATUS && pwdata[1]) begin
        lock_seen_reg <= 1'b0;
      end
    end
  end

  // Link requests: software commands first, then the automatic resume
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_reg    <= 1'b0;
      we_reg     <= 1'b0;
      addr_reg   <= 7'h00;
      wdata_reg  <= 8'h00;
      busy_reg   <= 1'b0;
      resume_reg <= 1'b0;
      rdata_reg  <= 8'h00;
      shadow_reg <= tssp_pkg::MAIN_RST;
    end else begin
      req_reg <= cmd_fire | res_fire;
      if (fall && ctrl_reg[tssp_pkg::CTRL_ARM] && ctrl_reg[tssp_pkg::CTRL_AUTO]) begin
        resume_reg <= 1'b1;
      end else if (res_fire) begin
        resume_reg <= 1'b0;
      end
      if (cmd_fire) begin
        we_reg    <= pwdata[tssp_pkg::CMD_WE_BIT];
        addr_reg  <= pwdata[tssp_pkg::CMD_ADDR_LSB +: 7];
        wdata_reg <= pwdata[7:0];
        busy_reg  <= 1'b1;
        if (pwdata[tssp_pkg::CMD_WE_BIT] &&
            pwdata[tssp_pkg::CMD_ADDR_LSB +: 7] == tssp_pkg::DEV_MAIN) begin
          shadow_reg <= pwdata[7:0];
        end
      end else if (res_fire) begin
        // Return the device to normal bit clock after lock
        we_reg    <= 1'b1;
        addr_reg  <= tssp_pkg::DEV_MAIN;
        wdata_reg <= shadow_reg & ~(8'h03 << tssp_pkg::MAIN_PDS_LSB);
        shadow_reg <= shadow_reg & ~(8'h03 << tssp_pkg::MAIN_PDS_LSB);
        busy_reg  <= 1'b1;
      end else if (link.cfg_ack) begin
        busy_reg <= 1'b0;
        if (!we_reg) begin
          rdata_reg <= link.cfg_rdata;
        end
      end
    end
  end

  assign link.cfg_req   = req_reg;
  assign link.cfg_we    = we_reg;
  assign link.cfg_addr  = addr_reg;
  assign link.cfg_wdata = wdata_reg;

  tssp_fifo #(
    .W (tssp_pkg::FIFO_WIDTH),
    .D (tssp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (pready && pwrite && paddr == tssp_pkg::H_TXDATA),
    .in_ready  (fifo_in_ready),
    .in_data   (pwdata[7:0]),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  // Serializer: MSB first, changes on the falling bit clock so the
  // device samples a settled level on the rising one
  assign fifo_pop = fall && ctrl_reg[tssp_pkg::CTRL_TXEN] && left_reg == 3'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_reg <= 1'b0;
      sh_reg   <= 8'h00;
      left_reg <= 3'h0;
    end else if (!ctrl_reg[tssp_pkg::CTRL_TXEN]) begin
      line_reg <= ctrl_reg[tssp_pkg::CTRL_IDLE];
      left_reg <= 3'h0;
    end else if (fall) begin
      if (left_reg != 3'h0) begin
        line_reg <= sh_reg[7];
        sh_reg   <= {sh_reg[6:0], 1'b0};
        left_reg <= left_reg - 3'h1;
      end else if (fifo_out_valid) begin
        line_reg <= fifo_data[7];
        sh_reg   <= {fifo_data[6:0], 1'b0};
        left_reg <= 3'h7;
      end
    end
  end

  assign link.tx_serial_input = line_reg;
endmodule // tssp_host

/* tssp_chk.sv */
module tssp_chk (
  input wire logic       pclk,            // Clock
  input wire logic       presetn,         // Reset, active low
  input wire logic       cfg_req,         // Access request
  input wire logic       cfg_we,          // Write flag
  input wire logic [6:0] cfg_addr,        // Register index
  input wire logic [7:0] cfg_wdata,       // Write data
  input wire logic       cfg_ack,         // Answer pulse
  input wire logic [7:0] cfg_rdata,       // Read data
  input wire logic       tx_serial_input, // Data line
  input wire logic       bit_clock_pin    // Bit clock or lock signal
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] pds_reg;    // Power-down code as last written
  logic [4:0] settle_reg; // Cycles left before whole clock phases return
  logic       span_off;   // Span checks blanked
  // Track the mode so the span checks only run on a free-running clock;
  // the pin rejoins the divider mid-phase, so a code change blanks them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pds_reg    <= 2'h0;
      settle_reg <= 5'h00;
    end else if (cfg_req && cfg_we && cfg_addr == tssp_pkg::DEV_MAIN &&
                 cfg_wdata[tssp_pkg::MAIN_PDS_LSB +: 2] != pds_reg) begin
      pds_reg    <= cfg_wdata[tssp_pkg::MAIN_PDS_LSB +: 2];
      settle_reg <= 5'h1F;
    end else if (settle_reg != 5'h00) begin
      settle_reg <= settle_reg - 5'h01;
    end
  end
  assign span_off = (pds_reg != tssp_pkg::PDS_NORMAL) || (settle_reg != 5'h00);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ack_after_req_a: assert property (cfg_req |=> cfg_ack) else $error("ack late");
  ack_cause_a: assert property (cfg_ack |-> $past(cfg_req)) else $error("stray ack");
  req_spacing_a: assert property (cfg_req |=> !cfg_req) else $error("req too close");
  fields_hold_a: assert property (cfg_req |=> $stable({cfg_we, cfg_addr, cfg_wdata}))
    else $error("fields moved");
  rdata_hold_a: assert property ($changed(cfg_rdata) |-> cfg_ack && !cfg_we)
    else $error("rdata moved");
  high_span_a: assert property (disable iff (!presetn || span_off)
    $rose(bit_clock_pin) |=> bit_clock_pin [*7] ##1 !bit_clock_pin) else $error("high span");
  low_span_a: assert property (disable iff (!presetn || span_off)
    $fell(bit_clock_pin) |=> !bit_clock_pin [*7] ##1 bit_clock_pin) else $error("low span");
  idle_reset_a: assert property (disable iff (1'b0) !presetn |-> !bit_clock_pin && !cfg_ack)
    else $error("reset not idle");
  cover property (cfg_ack && !cfg_we);
  cover property (pds_reg == 2'h1 && $fell(bit_clock_pin));
  cover property ($changed(tx_serial_input));
endmodule // tssp_chk

/* test_sequence_and_status_pins_bench.sv */
module test_sequence_and_status_pins_bench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [6:0] idx; // Device register
    logic [7:0] dat; // Value written
    logic       lk;  // Synthesizer lock
    logic [3:0] exp; // pa_on, bypass, amp enable, lock pin
  } tssp_row_t;
  tssp_row_t rows [11] = '{'{7'h01, 8'h08, 1'b0, 4'h2}, '{7'h01, 8'h01, 1'b0, 4'h4},
    '{7'h01, 8'h04, 1'b0, 4'h2}, '{7'h00, 8'h01, 1'b0, 4'h8}, '{7'h01, 8'h0C, 1'b0, 4'hA},
    '{7'h00, 8'h00, 1'b0, 4'h0}, '{7'h0C, 8'h10, 1'b0, 4'h1}, '{7'h0C, 8'h00, 1'b0, 4'h0},
    '{7'h0C, 8'h20, 1'b1, 4'h1}, '{7'h0C, 8'h20, 1'b0, 4'h0}, '{7'h0C, 8'h30, 1'b0, 4'h0}};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, lk, er;
  logic        mod_d, pa_on, amp_en, lock_pin, byp;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [39:0] s;       // Sampled test sequence
  int          err_count, num_checks, hi;
  tssp_if link();
  tssp_host u_tssp_host (.link(link), .pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr);
  tssp_device u_tssp_device (.link(link), .pclk, .presetn, .synth_locked_async(lk),
    .modulator_data(mod_d), .pa_on, .external_amp_enable_pin(amp_en), .lock_pin,
    .oscillator_bypass(byp));
  tssp_chk u_tssp_chk (.pclk, .presetn, .cfg_req(link.cfg_req), .cfg_we(link.cfg_we),
    .cfg_addr(link.cfg_addr), .cfg_wdata(link.cfg_wdata), .cfg_ack(link.cfg_ack),
    .cfg_rdata(link.cfg_rdata), .tx_serial_input(link.tx_serial_input),
    .bit_clock_pin(link.bit_clock_pin));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // One APB transfer; request held until pready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Device access through the command register, then wait for not busy
  task automatic dev(input logic w, input logic [6:0] i, input logic [7:0] d);
    apb(1'b1, tssp_pkg::H_CMD, {15'h0000, w, 1'b0, i, d});
    do apb(1'b0, tssp_pkg::H_STATUS, 32'h0000_0000); while (rd[0] !== 1'b0);
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    results();
  end
  initial begin
    // Scheduled update, so every flop already waits for the reset edge
    presetn <= 1'b0;
    {psel, penable, pwrite, lk} = '0;
    paddr = '0;
    pwdata = '0;
    err_count = 0;
    num_checks = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, tssp_pkg::H_STATUS, 32'h0000_0000);
    chk(rd[3:0], 4'hC);
    chk({pa_on, byp, amp_en, lock_pin}, 4'h0);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk(er, 1'b1);
    apb(1'b1, 12'h002, 32'h0000_0000);
    chk(er, 1'b1);
    $display("reset and map done");
    foreach (rows[i]) begin
      lk <= rows[i].lk;
      dev(1'b1, rows[i].idx, rows[i].dat);
      repeat (8) @(posedge pclk);
      chk({pa_on, byp, amp_en, lock_pin}, rows[i].exp);
    end
    dev(1'b0, 7'h01, 8'h00);
    chk(rd[15:8], 8'h0C);
    $display("pin rows done");
    dev(1'b1, 7'h01, 8'h02);
    dev(1'b1, 7'h00, 8'h10);
    // Arm only once the pin is held, so clock edges cannot fake a lock
    apb(1'b1, tssp_pkg::H_CTRL, 32'h0000_0001);
    repeat (8) @(posedge pclk);
    chk(link.bit_clock_pin, 1'b1);
    apb(1'b0, tssp_pkg::H_STATUS, 32'h0000_0000);
    chk(rd[1], 1'b0);
    lk <= 1'b1;
    repeat (8) @(posedge pclk);
    chk(link.bit_clock_pin, 1'b0);
    apb(1'b0, tssp_pkg::H_STATUS, 32'h0000_0000);
    chk(rd[1], 1'b1);
    apb(1'b1, tssp_pkg::H_STATUS, 32'h0000_0002);
    apb(1'b0, tssp_pkg::H_STATUS, 32'h0000_0000);
    chk(rd[1], 1'b0);
    dev(1'b1, 7'h00, 8'h00);
    lk <= 1'b0;
    repeat (20) @(posedge pclk);
    hi = 0;
    repeat (16) @(posedge pclk) hi += link.bit_clock_pin;
    chk(hi[7:0], 8'h08);
    // Automatic resume: the host itself clears the power-down code on lock
    dev(1'b1, 7'h00, 8'h10);
    apb(1'b1, tssp_pkg::H_CTRL, 32'h0000_0003);
    lk <= 1'b1;
    repeat (40) @(posedge pclk);
    dev(1'b0, 7'h00, 8'h00);
    chk(rd[15:8], 8'h00);
    $display("lock wait done");
    dev(1'b1, 7'h0B, 8'h01);
    // No data line movement yet, so the plain line level still goes out
    repeat (32) @(posedge pclk);
    chk(mod_d, 1'b0);
    apb(1'b1, tssp_pkg::H_CTRL, 32'h0000_0004);
    repeat (3) @(posedge link.bit_clock_pin);
    for (int n = 0; n < 40; n++) begin
      @(posedge link.bit_clock_pin);
      repeat (4) @(posedge pclk);
      s[n] = mod_d;
    end
    for (int n = 9; n < 40; n++) chk(s[n], s[n-9] ^ s[n-5]);
    chk(|s, 1'b1);
    $display("test sequence done");
    dev(1'b1, 7'h0B, 8'h00);
    apb(1'b1, tssp_pkg::H_CTRL, 32'h0000_0008);
    repeat (9) apb(1'b1, tssp_pkg::H_TXDATA, 32'h0000_00A5);
    apb(1'b0, tssp_pkg::H_STATUS, 32'h0000_0000);
    chk(rd[2], 1'b0);
    do apb(1'b0, tssp_pkg::H_STATUS, 32'h0000_0000); while (rd[3] !== 1'b1);
    chk(rd[2], 1'b1);
    $display("buffer done");
    results();
  end
endmodule // test_sequence_and_status_pins_bench
